// *** hw/lcc_pkg.sv ***
package lcc_pkg;

  // ==========================================================
  // Register map: printed offsets are word indices
  // ==========================================================
  localparam logic [7:0]  IDX_LEVEL1   = 8'h25;               // Level-one code and range select
  localparam logic [7:0]  IDX_LEVEL2   = 8'h26;               // Level-two code
  localparam logic [7:0]  IDX_LEVEL3   = 8'h27;               // Level-three code
  localparam logic [11:0] ADDR_LEVEL1  = {2'h0, IDX_LEVEL1, 2'h0};
  localparam logic [11:0] ADDR_LEVEL2  = {2'h0, IDX_LEVEL2, 2'h0};
  localparam logic [11:0] ADDR_LEVEL3  = {2'h0, IDX_LEVEL3, 2'h0};

  // ==========================================================
  // Field layout and reset values
  // ==========================================================
  localparam int          CODE_W       = 7;                   // Current code width
  localparam int          RANGE_BIT    = 7;                   // Range select position in level one
  localparam logic [6:0]  CODE_RST     = 7'h00;               // Codes start dark
  localparam logic        RANGE_RST    = 1'h0;                // Start on the 30 mA schedule
  localparam logic        RANGE_30MA   = 1'h0;                // Select value for 30 mA full scale
  localparam logic        RANGE_60MA   = 1'h1;                // Select value for 60 mA full scale
  localparam logic [1:0]  LEVEL_TWO    = 2'h2;                // Level select for level two
  localparam logic [1:0]  LEVEL_THREE  = 2'h3;                // Level select for level three

  // ==========================================================
  // Block state
  // ==========================================================
  typedef struct packed {
    logic              range_sel;                             // current_range_select
    logic [6:0]        level1_code;                           // Level-one code
    logic [6:0]        level2_code;                           // level2_current_code
    logic [6:0]        level3_code;                           // level3_current_code
    logic [31:0]       rdata;                                 // Captured read word
    logic              err;                                   // Captured unmapped flag
    logic              loaded;                                // Read word captured for this transfer
    logic [6:0]        drv_code;                              // Code handed to the sink DAC
    logic              drv_range;                             // Full-scale select for the sink DAC
  } lcc_state_s;

endpackage

// *** hw/lcc_top.sv ***
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module lcc_top
  import lcc_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Brightness level chosen by the light-sensing logic
  input  wire logic [1:0]  level_sel,
  // Sink DAC drive
  output logic [6:0]       drive_code,
  output logic             drive_range
);

  // ==========================================================
  // State and decode
  // ==========================================================
  lcc_state_s st_reg;                                         // All block state
  lcc_state_s st_next;                                        // Next value of the state
  logic       setup_ph;                                       // Transfer waiting for its read word
  logic       wr_done;                                        // Write completes this edge
  logic       hit1;                                           // Address hits level one
  logic       hit2;                                           // Address hits level two
  logic       hit3;                                           // Address hits level three

  // Address decoding on the held request
  assign hit1    = (paddr == ADDR_LEVEL1);
  assign hit2    = (paddr == ADDR_LEVEL2);
  assign hit3    = (paddr == ADDR_LEVEL3);

  // Ready only once the read word was captured, so a frozen setup cycle adds a wait
  assign pready   = psel && penable && pce && st_reg.loaded;
  assign setup_ph = psel && !st_reg.loaded;
  assign wr_done  = pready && pwrite;
  assign prdata   = st_reg.rdata;
  assign pslverr  = pready && st_reg.err;

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb
  begin
    st_next = st_reg;
    // Capture read word and error at the setup cycle
    if (setup_ph)
    begin
      st_next.loaded = 1'b1;
      st_next.err    = !(hit1 || hit2 || hit3);
      st_next.rdata  = '0;
      if (hit1)
      begin
        st_next.rdata[CODE_W:0] = {st_reg.range_sel, st_reg.level1_code};
      end
      else if (hit2)
      begin
        st_next.rdata[CODE_W-1:0] = st_reg.level2_code;
      end
      else if (hit3)
      begin
        st_next.rdata[CODE_W-1:0] = st_reg.level3_code;
      end
    end
    // Transfer ends at the ready edge
    if (pready)
    begin
      st_next.loaded = 1'b0;
    end
    // Writes land only at the completing edge and only with lane zero enabled
    if (wr_done && pstrb[0])
    begin
      if (hit1)
      begin
        st_next.range_sel   = pwdata[RANGE_BIT];
        st_next.level1_code = pwdata[CODE_W-1:0];
      end
      else if (hit2)
      begin
        st_next.level2_code = pwdata[CODE_W-1:0];
      end
      else if (hit3)
      begin
        st_next.level3_code = pwdata[CODE_W-1:0];
      end
    end
    // The DAC's own nonlinear ladder maps the code; we choose the code and full scale
    if (level_sel == LEVEL_TWO)
    begin
      st_next.drv_code = st_reg.level2_code;
    end
    else if (level_sel == LEVEL_THREE)
    begin
      st_next.drv_code = st_reg.level3_code;
    end
    else
    begin
      st_next.drv_code = st_reg.level1_code;
    end
    st_next.drv_range = st_reg.range_sel;
  end

  // ==========================================================
  // State register, frozen while the enable is low
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Constants only here; clearing the whole struct also drops any half-done capture
      st_reg             <= '0;
      st_reg.range_sel   <= RANGE_RST;
      st_reg.level1_code <= CODE_RST;
      st_reg.level2_code <= CODE_RST;
      st_reg.level3_code <= CODE_RST;
      st_reg.drv_code    <= CODE_RST;
      st_reg.drv_range   <= RANGE_RST;
    end
    else if (pce)
    begin
      st_reg <= st_next;
    end
  end

  assign drive_code  = st_reg.drv_code;
  assign drive_range = st_reg.drv_range;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Named steps of a read: an enabled setup cycle, then the completing access
  sequence seq_setup_read(logic [11:0] a);
    pce && psel && !penable && !pwrite && !st_reg.loaded && paddr == a;
  endsequence

  sequence seq_access_done;
    pce && psel && penable && pready;
  endsequence

  AST_L2_WRITE: assert property (wr_done && pstrb[0] && hit2 |=> st_reg.level2_code == $past(pwdata[6:0]))
    else $error("level two code not stored");
  AST_L3_WRITE: assert property (wr_done && pstrb[0] && hit3 |=> st_reg.level3_code == $past(pwdata[6:0]))
    else $error("level three code not stored");
  AST_RANGE_WRITE: assert property (wr_done && pstrb[0] && hit1 |=> st_reg.range_sel == $past(pwdata[RANGE_BIT]))
    else $error("range select not stored");
  AST_RANGE_30: assert property (pce && st_reg.range_sel == RANGE_30MA |=> drive_range == RANGE_30MA)
    else $error("30 mA range not driven");
  AST_RANGE_60: assert property (pce && st_reg.range_sel == RANGE_60MA |=> drive_range == RANGE_60MA)
    else $error("60 mA range not driven");
  AST_DRV_L2: assert property (pce && level_sel == LEVEL_TWO |=> drive_code == $past(st_reg.level2_code))
    else $error("level two code not driven");
  AST_DRV_L3: assert property (pce && level_sel == LEVEL_THREE |=> drive_code == $past(st_reg.level3_code))
    else $error("level three code not driven");
  AST_RSVD_ZERO: assert property (seq_setup_read(ADDR_LEVEL2) ##1 seq_access_done |-> prdata[31:7] == '0)
    else $error("reserved bits not zero");
  AST_L3_READ: assert property (seq_setup_read(ADDR_LEVEL3) ##1 seq_access_done |->
                                prdata[CODE_W-1:0] == st_reg.level3_code && !pslverr)
    else $error("level three readback wrong");

  // Level one reads back its code with the range select on top
  AST_L1_READ: assert property (seq_setup_read(ADDR_LEVEL1) ##1 seq_access_done |->
                                prdata[CODE_W:0] == {st_reg.range_sel, st_reg.level1_code} && !pslverr)
    else $error("level one readback wrong");

  // Level two reads back its stored code without an error
  AST_L2_READ: assert property (seq_setup_read(ADDR_LEVEL2) ##1 seq_access_done |->
                                prdata[CODE_W-1:0] == st_reg.level2_code && !pslverr)
    else $error("level two readback wrong");

  // Bit seven and up of level three read as zero
  AST_L3_RSVD: assert property (seq_setup_read(ADDR_LEVEL3) ##1 seq_access_done |-> prdata[31:CODE_W] == '0)
    else $error("level three reserved bits not zero");

  // ==========================================================
  // Bus timing and refusals
  // ==========================================================
  // The captured word is spent at the ready edge, so ready never stands two cycles
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held past one cycle");

  // Unmapped words answer with an error and read as zero
  AST_UNMAPPED: assert property (pready && !(hit1 || hit2 || hit3) |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");

  // Mapped words never answer with an error
  AST_MAPPED_OK: assert property (pready && (hit1 || hit2 || hit3) |-> !pslverr)
    else $error("mapped access answered with error");

  // Lane zero off: the write is dropped quietly
  AST_STRB_OFF: assert property (wr_done && !pstrb[0] |=> st_reg.level2_code == $past(st_reg.level2_code)
                                 && st_reg.level3_code == $past(st_reg.level3_code))
    else $error("write with lane zero off changed a code");

  // ==========================================================
  // Clock enable and drive selection
  // ==========================================================
  // A low enable freezes every bit of state, bus capture included
  AST_FREEZE: assert property (!pce |=> st_reg == $past(st_reg))
    else $error("state moved while enable low");

  // Levels zero and one fall back to the level-one code
  AST_DRV_L1: assert property (pce && level_sel != LEVEL_TWO && level_sel != LEVEL_THREE |=>
                               drive_code == $past(st_reg.level1_code))
    else $error("level one code not driven");

endmodule

// *** verification/lcc_tb.sv ***
`timescale 1ns/1ps
module testbench;
  import lcc_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  logic        pclk, presetn, pce, psel, penable, pwrite; // Clock, reset, bus control
  logic [11:0] paddr;                                     // Byte address
  logic [31:0] pwdata, prdata, rd_val;                    // Bus data and last read word
  logic [3:0]  pstrb;                                     // Byte strobes
  logic        pready, pslverr, drive_range, rd_err;      // Answers and sink range
  logic [1:0]  level_sel;                                 // Active brightness level
  logic [6:0]  drive_code;                                // Code to the sink DAC
  int          n_fail, num_checks;                        // Mismatch and compare counts

  lcc_top uut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .level_sel(level_sel), .drive_code(drive_code),
    .drive_range(drive_range));

  // Free-running 40 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ==========================================================
  // Shared tasks
  // ==========================================================
  // Counts every compare; four-state equality so X never matches
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Single exit point for pass, fail and timeout
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer, entered just after a rising edge; an idle cycle follows
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready is sampled at the rising edge itself; the request stands unchanged until then
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      n_fail++;
      complete_run();
    end
    // Answer taken at the same edge that saw ready high, then the request is released
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Read a register and compare data byte and error flag
  task automatic rdc(input string what, input logic [11:0] a, input logic [7:0] exp, input logic err);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    check(what, rd_val, {24'h000000, exp});
    check("read error flag", {31'h0, rd_err}, {31'h0, err});
  endtask

  // Select a level, let the registered drive settle, compare code and range
  task automatic drv(input logic [1:0] ls, input logic [6:0] code, input logic rng);
    level_sel <= ls;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check("drive code", {25'h0, drive_code}, {25'h0, code});
    check("drive range", {31'h0, drive_range}, {31'h0, rng});
    @(posedge pclk);
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    n_fail = 0; num_checks = 0;
    presetn = 1'b0; pce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0; level_sel = 2'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("level2 reset", ADDR_LEVEL2, 8'h00, 1'b0);
    rdc("level3 reset", ADDR_LEVEL3, 8'h00, 1'b0);
    drv(LEVEL_TWO, 7'h00, RANGE_30MA);
    // Reserved top bit must never reach the stored code
    apb(1'b1, ADDR_LEVEL2, 32'hffff_ffff, 4'hf);
    rdc("level2 all ones", ADDR_LEVEL2, 8'h7f, 1'b0);
    apb(1'b1, ADDR_LEVEL3, 32'h0000_00d5, 4'hf);
    rdc("level3 code", ADDR_LEVEL3, 8'h55, 1'b0);
    // Low strobe clear: write dropped without error
    apb(1'b1, ADDR_LEVEL3, 32'h0000_0012, 4'he);
    rdc("level3 strobe off", ADDR_LEVEL3, 8'h55, 1'b0);
    // Wide range with the mid-table code in level one
    apb(1'b1, ADDR_LEVEL1, 32'h0000_00c0, 4'hf);
    rdc("level1 range set", ADDR_LEVEL1, 8'hc0, 1'b0);
    drv(2'h0, 7'h40, RANGE_60MA);
    drv(2'h1, 7'h40, RANGE_60MA);
    drv(LEVEL_TWO, 7'h7f, RANGE_60MA);
    drv(LEVEL_THREE, 7'h55, RANGE_60MA);
    // Narrow range, then a dark code
    apb(1'b1, ADDR_LEVEL1, 32'h0000_007e, 4'hf);
    drv(LEVEL_THREE, 7'h55, RANGE_30MA);
    drv(2'h0, 7'h7e, RANGE_30MA);
    apb(1'b1, ADDR_LEVEL2, 32'h0000_0080, 4'hf);
    drv(LEVEL_TWO, 7'h00, RANGE_30MA);
    // Enable low: a new level choice must not reach the drive until enable returns
    pce <= 1'b0;
    level_sel <= LEVEL_THREE;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    check("frozen drive code", {25'h0, drive_code}, 32'h0000_0000);
    @(posedge pclk);
    pce <= 1'b1;
    drv(LEVEL_THREE, 7'h55, RANGE_30MA);
    // Past the map: error answer, read zero
    apb(1'b1, 12'h0a0, 32'h0000_00ff, 4'hf);
    check("unmapped write error", {31'h0, rd_err}, 32'h0000_0001);
    rdc("unmapped read", 12'h0a0, 8'h00, 1'b1);
    rdc("level2 after unmapped", ADDR_LEVEL2, 8'h00, 1'b0);
    complete_run();
  end
endmodule
